// ===== adcsq_ctrl.sv
// Converter sequencing control: APB register bank, start logic, sleep handling.
// Assumes the analog core presents a settled 10-bit sample on conv_sample at the
// end of each sampling period, and the sleep controller drives level sleep inputs.
`timescale 1ns/100ps
// Function
// - Standby without standby-run stops the converter
// - Standby-run keeps converter fully working in standby
// - Ongoing conversion completes, interrupts raised, in standby with standby-run
// - Clock requested only while converting, then released
// - Event rising edge sets start command, starts
// - Completion sets result-ready, clears start command
// - No conversion starts during power-down
// - Power-down freezes conversion; flag set later, result invalid
// - Resolution zero stores full ten-bit value
// - Resolution one drops two low bits
// - Continuous mode restarts right after each completion
// - Control A bit zero enables the converter
// - Standby-run is control A bit seven, resets zero
// - Event start accepted only with event-start enable
// - Interrupt asserted while flag and enable both set
module adcsq_ctrl #(
   parameter int SAMPLE_TICKS = adcsq_pkg::SAMPLE_TICKS
) (
   // Clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Event and sleep inputs
   input  wire logic        event_trigger,
   input  wire logic        sleep_standby,
   input  wire logic        sleep_powerdown,
   // Analog core
   input  wire logic [9:0]  conv_sample,
   output logic             conv_active,
   // System outputs
   output logic             clk_request,
   output logic             irq
);
   // Register storage
   logic [7:0]  control_a, control_b, control_c, control_d, control_e;
   logic [7:0]  sample_length_ctrl, input_select, event_control, irq_enable;
   logic [7:0]  irq_flags, debug_control, scratch_byte, calibration;
   logic [15:0] conversion_result, window_low_threshold, window_high_threshold;
   logic        start_conversion_cmd;
   // Sequencer
   adcsq_pkg::adcsq_state_t state;
   logic [7:0]  div_cnt;
   logic [8:0]  init_cnt;
   logic [7:0]  tick_cnt;
   logic [6:0]  samp_cnt;
   logic [15:0] acc;
   logic        init_pending;
   logic        event_prev;
   logic        enable_prev;
   // Decoded controls
   logic        enable, continuous_conv_mode, resolution_select, standby_run_bit;
   logic        event_start_enable, run_ok, tick, sample_end, conv_done;
   logic        wr_en, rd_setup, sw_start, ev_start, start_req, win_hit;
   logic [7:0]  widx;
   logic [15:0] scaled, final_value;
   logic [31:0] next_prdata;
   logic        mapped;
   assign enable               = control_a[adcsq_pkg::BIT_ENABLE];
   assign continuous_conv_mode = control_a[adcsq_pkg::BIT_CONT_MODE];
   assign resolution_select    = control_a[adcsq_pkg::BIT_RES_SELECT];
   assign standby_run_bit      = control_a[adcsq_pkg::BIT_STANDBY_RUN];
   assign event_start_enable   = event_control[adcsq_pkg::BIT_EVENT_START];
   // Converter may advance only when enabled and not held by sleep
   assign run_ok = enable && !sleep_powerdown
                   && (!sleep_standby || standby_run_bit);
   // Clock divider period from prescaler field, minus one
   function automatic logic [7:0] div_max(input logic [2:0] presc);
      div_max = 8'((9'h002 << presc) - 9'h001);
   endfunction : div_max
   // Init delay in converter ticks; reserved codes act as the longest delay
   function automatic logic [8:0] init_ticks(input logic [2:0] sel);
      init_ticks = (sel == 3'h0) ? 9'h000 :
                   (sel > 3'h5)  ? 9'h100 : 9'(9'h008 << sel);
   endfunction : init_ticks
   // Samples per result, minus one; reserved code treated as largest
   function automatic logic [6:0] acc_last(input logic [2:0] sel);
      logic [2:0] s;
      s = (sel > adcsq_pkg::ACC_MAX_SEL) ? adcsq_pkg::ACC_MAX_SEL : sel;
      acc_last = 7'((8'h01 << s) - 8'h01);
   endfunction : acc_last
   // Window comparison on the final accumulated value
   function automatic logic win_check(input logic [2:0] mode, input logic [15:0] v,
                                      input logic [15:0] lo, input logic [15:0] hi);
      unique case (mode)
         adcsq_pkg::WIN_BELOW:   win_check = (v < lo);
         adcsq_pkg::WIN_ABOVE:   win_check = (v > hi);
         adcsq_pkg::WIN_INSIDE:  win_check = (v > lo) && (v < hi);
         adcsq_pkg::WIN_OUTSIDE: win_check = (v < lo) || (v > hi);
         default:                win_check = 1'b0;
      endcase
   endfunction : win_check
   // Sample scaling: full width or eight MSBs
   assign scaled = resolution_select ? {8'h00, conv_sample[9:2]}
                                     : {6'h00, conv_sample};
   assign final_value = acc + scaled;
   // Converter tick and sample boundaries
   assign tick       = run_ok && (state != adcsq_pkg::ST_IDLE)
                       && (div_cnt == div_max(control_c[2:0]));
   assign sample_end = tick && (state == adcsq_pkg::ST_CONV)
                       && (tick_cnt == 8'(SAMPLE_TICKS - 1));
   assign conv_done  = sample_end && (samp_cnt == acc_last(control_b[2:0]));
   assign win_hit    = win_check(control_e[2:0], final_value,
                                 window_low_threshold, window_high_threshold);
   // APB decode; zero wait states, read data captured in setup phase
   assign widx     = 8'(paddr >> adcsq_pkg::BYTE_SHIFT);
   assign wr_en    = psel && penable && pwrite && clk_en && mapped;
   assign rd_setup = psel && !penable && !pwrite && clk_en;
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !mapped;
   // Start sources; sleep and disable block them
   assign sw_start  = wr_en && (widx == adcsq_pkg::IDX_COMMAND)
                      && pwdata[adcsq_pkg::BIT_START_CMD];
   assign ev_start  = event_trigger && !event_prev && event_start_enable;
   assign start_req = (sw_start || ev_start) && run_ok;
   // Read mux and address validity
   always_comb begin
      next_prdata = 32'h0000_0000;
      mapped      = 1'b1;
      unique case (widx)
         adcsq_pkg::IDX_CONTROL_A:     next_prdata[7:0] = control_a;
         adcsq_pkg::IDX_CONTROL_B:     next_prdata[7:0] = control_b;
         adcsq_pkg::IDX_CONTROL_C:     next_prdata[7:0] = control_c;
         adcsq_pkg::IDX_CONTROL_D:     next_prdata[7:0] = control_d;
         adcsq_pkg::IDX_CONTROL_E:     next_prdata[7:0] = control_e;
         adcsq_pkg::IDX_SAMPLE_LEN:    next_prdata[7:0] = sample_length_ctrl;
         adcsq_pkg::IDX_INPUT_SELECT:  next_prdata[7:0] = input_select;
         adcsq_pkg::IDX_COMMAND:       next_prdata[0]   = start_conversion_cmd;
         adcsq_pkg::IDX_EVENT_CONTROL: next_prdata[7:0] = event_control;
         adcsq_pkg::IDX_IRQ_ENABLE:    next_prdata[7:0] = irq_enable;
         adcsq_pkg::IDX_IRQ_FLAGS:     next_prdata[7:0] = irq_flags;
         adcsq_pkg::IDX_DEBUG_CONTROL: next_prdata[7:0] = debug_control;
         adcsq_pkg::IDX_SCRATCH_BYTE:  next_prdata[7:0] = scratch_byte;
         adcsq_pkg::IDX_RESULT:        next_prdata[15:0] = conversion_result;
         adcsq_pkg::IDX_WIN_LOW:       next_prdata[15:0] = window_low_threshold;
         adcsq_pkg::IDX_WIN_HIGH:      next_prdata[15:0] = window_high_threshold;
         adcsq_pkg::IDX_CALIBRATION:   next_prdata[7:0] = calibration;
         default:                      mapped = 1'b0;
      endcase
      if (paddr[1:0] != 2'b00) begin
         mapped      = 1'b0;
         next_prdata = 32'h0000_0000;
      end
   end

   // Read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= next_prdata;
      end
   end

   // Plain configuration registers; writes mask reserved bits to zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_a             <= adcsq_pkg::REG_RESET;
         control_b             <= adcsq_pkg::REG_RESET;
         control_c             <= adcsq_pkg::REG_RESET;
         control_d             <= adcsq_pkg::REG_RESET;
         control_e             <= adcsq_pkg::REG_RESET;
         sample_length_ctrl    <= adcsq_pkg::REG_RESET;
         input_select          <= adcsq_pkg::REG_RESET;
         event_control         <= adcsq_pkg::REG_RESET;
         irq_enable            <= adcsq_pkg::REG_RESET;
         debug_control         <= adcsq_pkg::REG_RESET;
         scratch_byte          <= adcsq_pkg::REG_RESET;
         calibration           <= adcsq_pkg::REG_RESET;
         window_low_threshold  <= adcsq_pkg::WORD_RESET;
         window_high_threshold <= adcsq_pkg::WORD_RESET;
      end else if (wr_en) begin
         unique case (widx)
            adcsq_pkg::IDX_CONTROL_A:     control_a <= pwdata[7:0] & adcsq_pkg::CONTROL_A_MASK;
            adcsq_pkg::IDX_CONTROL_B:     control_b <= pwdata[7:0] & adcsq_pkg::CONTROL_B_MASK;
            adcsq_pkg::IDX_CONTROL_C:     control_c <= pwdata[7:0] & adcsq_pkg::CONTROL_C_MASK;
            adcsq_pkg::IDX_CONTROL_D:     control_d <= pwdata[7:0];
            adcsq_pkg::IDX_CONTROL_E:     control_e <= pwdata[7:0] & adcsq_pkg::CONTROL_E_MASK;
            adcsq_pkg::IDX_SAMPLE_LEN:
               sample_length_ctrl <= pwdata[7:0] & adcsq_pkg::SAMPLE_LEN_MASK;
            adcsq_pkg::IDX_INPUT_SELECT:  input_select <= pwdata[7:0] & adcsq_pkg::INPUT_SEL_MASK;
            adcsq_pkg::IDX_EVENT_CONTROL: event_control <= pwdata[7:0] & adcsq_pkg::BIT0_MASK;
            adcsq_pkg::IDX_IRQ_ENABLE:    irq_enable <= pwdata[7:0] & adcsq_pkg::FLAGS_MASK;
            adcsq_pkg::IDX_DEBUG_CONTROL: debug_control <= pwdata[7:0] & adcsq_pkg::BIT0_MASK;
            adcsq_pkg::IDX_SCRATCH_BYTE:  scratch_byte <= pwdata[7:0];
            adcsq_pkg::IDX_WIN_LOW:       window_low_threshold <= pwdata[15:0];
            adcsq_pkg::IDX_WIN_HIGH:      window_high_threshold <= pwdata[15:0];
            adcsq_pkg::IDX_CALIBRATION:   calibration <= pwdata[7:0] & adcsq_pkg::BIT0_MASK;
            default: ;
         endcase
      end
   end

   // Edge trackers for event input and enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_prev  <= 1'b0;
         enable_prev <= 1'b0;
      end else if (clk_en) begin
         event_prev  <= event_trigger;
         enable_prev <= enable;
      end
   end

   // Start command bit; a new request wins over the completion clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_conversion_cmd <= 1'b0;
      end else if (clk_en) begin
         if (!enable) begin
            start_conversion_cmd <= 1'b0;
         end else if (start_req) begin
            start_conversion_cmd <= 1'b1;
         end else if (conv_done) begin
            start_conversion_cmd <= 1'b0;
         end
      end
   end

   // Init delay is owed after each enable, so the reference can settle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_pending <= 1'b0;
      end else if (clk_en) begin
         if (enable && !enable_prev) begin
            init_pending <= 1'b1;
         end else if (state == adcsq_pkg::ST_INIT || !enable) begin
            init_pending <= 1'b0;
         end
      end
   end

   // Clock divider; counts only while converting so it stops with the clock request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= 8'h00;
      end else if (clk_en) begin
         if (state == adcsq_pkg::ST_IDLE || !enable) begin
            div_cnt <= 8'h00;
         end else if (run_ok) begin
            div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
         end
      end
   end

   // Sequencer: idle, init delay, sampling; frozen while enabled and run_ok is low, forced to idle when disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= adcsq_pkg::ST_IDLE;
         init_cnt <= 9'h000;
         tick_cnt <= 8'h00;
         samp_cnt <= 7'h00;
         acc      <= 16'h0000;
      end else if (clk_en) begin
         if (!enable) begin
            state <= adcsq_pkg::ST_IDLE;
         end else begin
            unique case (state)
               adcsq_pkg::ST_IDLE: begin
                  tick_cnt <= 8'h00;
                  samp_cnt <= 7'h00;
                  acc      <= 16'h0000;
                  init_cnt <= 9'h000;
                  if (start_conversion_cmd && run_ok) begin
                     state <= (init_pending && init_ticks(control_d[7:5]) != 9'h000)
                              ? adcsq_pkg::ST_INIT : adcsq_pkg::ST_CONV;
                  end
               end
               adcsq_pkg::ST_INIT: begin
                  if (tick) begin
                     init_cnt <= init_cnt + 9'h001;
                     if (init_cnt == init_ticks(control_d[7:5]) - 9'h001) begin
                        state <= adcsq_pkg::ST_CONV;
                     end
                  end
               end
               adcsq_pkg::ST_CONV: begin
                  if (tick) begin
                     tick_cnt <= sample_end ? 8'h00 : tick_cnt + 8'h01;
                  end
                  if (conv_done) begin
                     samp_cnt <= 7'h00;
                     acc      <= 16'h0000;
                     // Continuous mode chains straight into the next cycle
                     if (!continuous_conv_mode) begin
                        state <= adcsq_pkg::ST_IDLE;
                     end
                  end else if (sample_end) begin
                     samp_cnt <= samp_cnt + 7'h01;
                     acc      <= final_value;
                  end
               end
               default: state <= adcsq_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // Result store; after a power-down freeze the value is stale by nature
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conversion_result <= 16'h0000;
      end else if (clk_en && conv_done) begin
         conversion_result <= final_value;
      end
   end

   // Sticky flags, write one to clear; hardware set wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_flags <= adcsq_pkg::REG_RESET;
      end else if (clk_en) begin
         if (wr_en && widx == adcsq_pkg::IDX_IRQ_FLAGS) begin
            irq_flags <= irq_flags & ~(pwdata[7:0] & adcsq_pkg::FLAGS_MASK);
         end
         if (conv_done) begin
            irq_flags[adcsq_pkg::BIT_FLAG_RESULT_READY_FLAG] <= 1'b1;
            if (win_hit) begin
               irq_flags[adcsq_pkg::BIT_FLAG_WINDOW] <= 1'b1;
            end
         end
      end
   end

   // Outputs: interrupt level, clock request, sampling activity
   assign irq         = |(irq_flags & irq_enable);
   assign clk_request = enable && (state != adcsq_pkg::ST_IDLE
                        || start_conversion_cmd);
   assign conv_active = (state == adcsq_pkg::ST_CONV) && run_ok;
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_event_edge;
      clk_en && !event_trigger ##1 clk_en && event_trigger;
   endsequence

   a_event_sets_cmd: assert property (
      s_event_edge ##0 (event_start_enable && run_ok) |=> start_conversion_cmd)
      else $error("event edge did not set start command");
   a_event_gated: assert property (
      s_event_edge ##0 (!event_start_enable && !sw_start && !start_conversion_cmd)
      |=> !start_conversion_cmd)
      else $error("event start accepted while disabled");
   a_done_flag_cmd: assert property (
      clk_en && conv_done && !start_req |=> irq_flags[0] && !start_conversion_cmd)
      else $error("completion did not set flag and clear command");
   a_pdown_no_start: assert property (
      sleep_powerdown && state == adcsq_pkg::ST_IDLE |=> state == adcsq_pkg::ST_IDLE)
      else $error("conversion started in power-down");
   a_freeze_hold: assert property (
      clk_en && enable && !run_ok && state != adcsq_pkg::ST_IDLE
      |=> $stable(tick_cnt) && $stable(samp_cnt) && $stable(state))
      else $error("conversion advanced while frozen");
   a_disabled_idle: assert property (
      clk_en && !enable |=> state == adcsq_pkg::ST_IDLE && !start_conversion_cmd
                           && $stable(irq_flags) || $past(wr_en))
      else $error("disabled converter still active");
   a_res_eight: assert property (
      clk_en && conv_done && resolution_select && control_b[2:0] == 3'h0
      |=> conversion_result == {8'h00, $past(conv_sample[9:2])})
      else $error("eight-bit result wrong");
   a_res_ten: assert property (
      clk_en && conv_done && !resolution_select && control_b[2:0] == 3'h0
      |=> conversion_result == {6'h00, $past(conv_sample)})
      else $error("ten-bit result wrong");
   a_cont_restart: assert property (
      clk_en && conv_done && continuous_conv_mode && enable
      |=> state == adcsq_pkg::ST_CONV && tick_cnt == 8'h00)
      else $error("continuous mode did not restart");
   a_clk_release: assert property (
      clk_en && conv_done && !continuous_conv_mode && !start_req |=> !clk_request)
      else $error("clock request held after completion");
   a_irq_level: assert property (
      irq_flags[0] && irq_enable[0] |-> irq)
      else $error("interrupt not asserted for set flag");
endmodule : adcsq_ctrl

// ===== adcsq_pkg.sv
// Package for the converter sequencing control block.
// Assumes an APB slave with 32-bit data; each register is one word at index*4.
package adcsq_pkg;
   // Register indices, address width and the shift to byte addresses
   localparam logic [7:0] IDX_CONTROL_A      = 8'h00;
   localparam logic [7:0] IDX_CONTROL_B      = 8'h01;
   localparam logic [7:0] IDX_CONTROL_C      = 8'h02;
   localparam logic [7:0] IDX_CONTROL_D      = 8'h03;
   localparam logic [7:0] IDX_CONTROL_E      = 8'h04;
   localparam logic [7:0] IDX_SAMPLE_LEN     = 8'h05;
   localparam logic [7:0] IDX_INPUT_SELECT   = 8'h06;
   localparam logic [7:0] IDX_COMMAND        = 8'h08;
   localparam logic [7:0] IDX_EVENT_CONTROL  = 8'h09;
   localparam logic [7:0] IDX_IRQ_ENABLE     = 8'h0a;
   localparam logic [7:0] IDX_IRQ_FLAGS      = 8'h0b;
   localparam logic [7:0] IDX_DEBUG_CONTROL  = 8'h0c;
   localparam logic [7:0] IDX_SCRATCH_BYTE   = 8'h0d;
   localparam logic [7:0] IDX_RESULT         = 8'h10;
   localparam logic [7:0] IDX_WIN_LOW        = 8'h12;
   localparam logic [7:0] IDX_WIN_HIGH       = 8'h14;
   localparam logic [7:0] IDX_CALIBRATION    = 8'h16;
   localparam int         ADDR_W             = 8;
   localparam int         BYTE_SHIFT         = 2;

   // Control A fields
   localparam int BIT_ENABLE       = 0;
   localparam int BIT_CONT_MODE    = 1;
   localparam int BIT_RES_SELECT   = 2;
   localparam int BIT_STANDBY_RUN  = 7;
   localparam logic [7:0] CONTROL_A_MASK = 8'h87;
   // Other fields
   localparam int BIT_START_CMD    = 0;
   localparam int BIT_EVENT_START  = 0;
   localparam int BIT_FLAG_RESULT_READY_FLAG  = 0;
   localparam int BIT_FLAG_WINDOW  = 1;
   localparam logic [7:0] FLAGS_MASK      = 8'h03;
   localparam logic [7:0] CONTROL_B_MASK  = 8'h07;
   localparam logic [7:0] CONTROL_C_MASK  = 8'h77;
   localparam logic [7:0] CONTROL_E_MASK  = 8'h07;
   localparam logic [7:0] SAMPLE_LEN_MASK = 8'h1f;
   localparam logic [7:0] INPUT_SEL_MASK  = 8'h1f;
   localparam logic [7:0] BIT0_MASK       = 8'h01;
   localparam logic [7:0] REG_RESET       = 8'h00;
   localparam logic [15:0] WORD_RESET     = 16'h0000;

   // Window comparator modes
   localparam logic [2:0] WIN_NONE    = 3'h0;
   localparam logic [2:0] WIN_BELOW   = 3'h1;
   localparam logic [2:0] WIN_ABOVE   = 3'h2;
   localparam logic [2:0] WIN_INSIDE  = 3'h3;
   localparam logic [2:0] WIN_OUTSIDE = 3'h4;

   // Timing: converter clock ticks per sample, largest accumulation select
   localparam int         SAMPLE_TICKS   = 13;
   localparam logic [2:0] ACC_MAX_SEL    = 3'h6;

   // Sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_INIT, ST_CONV} adcsq_state_t;
endpackage : adcsq_pkg

// ===== adcsq_far_model.sv
// Far side model: analog sample source and event routing line.
// Assumes the bench raises fire to ask for a rising event edge.
`timescale 1ns/100ps
module adcsq_far_model (
   // Clock and request from the bench
   input  wire logic       pclk,
   input  wire logic       fire,
   // Toward the block
   output logic      [9:0] conv_sample,
   output logic            event_trigger
);
   // Fixed sample, so that scaled results are known
   assign conv_sample = 10'h2d7;
   // Registered so the edge lands just after a clock edge; settles during reset
   always @(posedge pclk) event_trigger <= fire;
endmodule : adcsq_far_model

// ===== adcsq_ctrl_tb_top.sv
// Bench for the converter sequencing control, APB tasks and checks.
// Assumes the far side model feeds samples and events.
`timescale 1ns/100ps
module adcsq_ctrl_tb_top;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, fire = 1'b0, sb = 1'b0, pd = 1'b0, slverr;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, q;
   logic        pready, pslverr, clk_request, irq, event_trigger;
   logic [9:0]  conv_sample;
   int          errors = 0, cmp_count = 0;
   // Clock at 100 MHz
   always #5 pclk = ~pclk;
   // Short sample keeps the run brief
   adcsq_ctrl #(.SAMPLE_TICKS(2)) dut_u (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_trigger(event_trigger),
      .sleep_standby(sb), .sleep_powerdown(pd), .conv_sample(conv_sample),
      .conv_active(), .clk_request(clk_request), .irq(irq));
   adcsq_far_model far_u (.pclk(pclk), .fire(fire), .conv_sample(conv_sample),
      .event_trigger(event_trigger));
   // One APB transfer; request held until pready is seen
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx[5:0], 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Bounded wait; a refused start must leave irq low at the end of the span
   task automatic wait_irq(input logic e);
      for (int n = 0; n < 60 && !(e && irq === 1'b1); n++) @(posedge pclk);
      chk(32'(irq), 32'(e));
   endtask : wait_irq
   // Clear flags, set mode; start by command before sleeping, or by event in sleep
   task automatic run_case(input logic [7:0] ctl, input logic s, p, e, ev);
      apb(1'b1, adcsq_pkg::IDX_IRQ_FLAGS, 32'h0000_0003);
      apb(1'b1, adcsq_pkg::IDX_CONTROL_A, {24'h00_0000, ctl});
      apb(1'b1, adcsq_pkg::IDX_EVENT_CONTROL, 32'(ev));
      if (!ev) apb(1'b1, adcsq_pkg::IDX_COMMAND, 32'h0000_0001);
      sb <= s;
      pd <= p;
      fire <= ev;
      wait_irq(e);
      sb <= 1'b0;
      pd <= 1'b0;
      fire <= 1'b0;
   endtask : run_case
   task automatic final_report;
      $display("errors=%0d comparisons=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report
   // Hang guard, far beyond the expected several hundred cycles
   initial begin
      #100us;
      errors++;
      final_report();
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, adcsq_pkg::IDX_CONTROL_A, 32'h0);
      chk(q, 32'h0000_0000);
      apb(1'b0, 8'h07, 32'h0);
      chk(32'(slverr), 32'h0000_0001);
      apb(1'b1, adcsq_pkg::IDX_IRQ_ENABLE, 32'h0000_0001);
      apb(1'b1, adcsq_pkg::IDX_CONTROL_D, 32'h0000_0020);
      run_case(8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
      run_case(8'h01, 1'b0, 1'b1, 1'b0, 1'b1);
      run_case(8'h01, 1'b1, 1'b0, 1'b0, 1'b1);
      run_case(8'h81, 1'b1, 1'b0, 1'b1, 1'b1);
      run_case(8'h81, 1'b1, 1'b0, 1'b1, 1'b0);
      run_case(8'h01, 1'b0, 1'b1, 1'b0, 1'b0);
      wait_irq(1'b1);
      run_case(8'h01, 1'b0, 1'b0, 1'b1, 1'b0);
      apb(1'b0, adcsq_pkg::IDX_RESULT, 32'h0);
      chk(q, 32'h0000_02d7);
      apb(1'b0, adcsq_pkg::IDX_COMMAND, 32'h0);
      chk(q, 32'h0000_0000);
      chk(32'(clk_request), 32'h0000_0000);
      apb(1'b1, adcsq_pkg::IDX_IRQ_ENABLE, 32'h0);
      chk(32'(irq), 32'h0000_0000);
      apb(1'b1, adcsq_pkg::IDX_IRQ_ENABLE, 32'h0000_0001);
      apb(1'b1, adcsq_pkg::IDX_CONTROL_A, 32'h0000_0005);
      apb(1'b1, adcsq_pkg::IDX_EVENT_CONTROL, 32'h0000_0001);
      apb(1'b1, adcsq_pkg::IDX_IRQ_FLAGS, 32'h0000_0003);
      fire <= 1'b1;
      wait_irq(1'b1);
      fire <= 1'b0;
      apb(1'b0, adcsq_pkg::IDX_RESULT, 32'h0);
      chk(q, 32'h0000_00b5);
      apb(1'b1, adcsq_pkg::IDX_EVENT_CONTROL, 32'h0);
      apb(1'b1, adcsq_pkg::IDX_IRQ_FLAGS, 32'h0000_0003);
      fire <= 1'b1;
      wait_irq(1'b0);
      run_case(8'h03, 1'b0, 1'b0, 1'b1, 1'b0);
      apb(1'b1, adcsq_pkg::IDX_IRQ_FLAGS, 32'h0000_0003);
      wait_irq(1'b1);
      final_report();
   end
endmodule : adcsq_ctrl_tb_top
